// *** rtl/output_divider_channel_pkg.sv ***
// constants for the output divider channel block
package output_divider_channel_pkg;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_SYNC_CONTROL       = 8'h14;
   localparam logic [7:0] ADDR_CH0_POWER_SYNC     = 8'h19;
   localparam logic [7:0] ADDR_CH0_SINGLE_ENDED   = 8'h1a;
   localparam logic [7:0] ADDR_CH1_DIVIDE_LOW     = 8'h1b;
   localparam logic [7:0] ADDR_CH1_DIVIDE_HIGH    = 8'h1c;
   localparam logic [7:0] ADDR_CH1_PHASE_LOW      = 8'h1d;
   localparam logic [7:0] ADDR_CH1_PHASE_HIGH     = 8'h1e;

   // -------------------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------------------
   localparam logic [7:0] RST_SYNC_CONTROL        = 8'h01;
   localparam logic [7:0] RST_CH0_POWER_SYNC      = 8'h14;
   localparam logic [7:0] RST_CH0_SINGLE_ENDED    = 8'h00;
   localparam logic [7:0] RST_CH1_BYTE            = 8'h00;
   localparam logic [7:0] MASK_SYNC_CONTROL       = 8'h01;
   localparam logic [7:0] MASK_CH0_POWER_SYNC     = 8'hfe;
   localparam logic [7:0] MASK_CH0_SINGLE_ENDED   = 8'hfc;
   localparam logic [7:0] MASK_FULL               = 8'hff;
   localparam logic [7:0] MASK_CH1_DIVIDE_HIGH    = 8'h03;
   localparam logic [7:0] MASK_CH1_PHASE_HIGH     = 8'h07;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int SYNC_BIT_POS          = 0;
   localparam int PWR_DOWN_POS          = 7;
   localparam int ALIGN_EXCL_POS        = 6;
   localparam int DIFF_POL_LSB          = 4;
   localparam int DIFF_FMT_LSB          = 1;
   localparam int POS_EN_POS            = 7;
   localparam int POS_POL_LSB           = 5;
   localparam int NEG_EN_POS            = 4;
   localparam int NEG_POL_LSB           = 2;
   localparam int DIVIDE_WIDTH          = 10;
   localparam int PHASE_WIDTH           = 11;

   // -------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------
   localparam logic [1:0] POL_FORCE_HIGH  = 2'h0;
   localparam logic [1:0] POL_NONINVERT   = 2'h1;
   localparam logic [1:0] POL_INVERT      = 2'h2;
   localparam logic [1:0] POL_FORCE_LOW   = 2'h3;
   localparam logic [2:0] FMT_LVDS_HALF   = 3'h0;
   localparam logic [2:0] FMT_LVDS_3Q     = 3'h1;
   localparam logic [2:0] FMT_LVDS_FULL   = 3'h2;
   localparam logic [2:0] FMT_LVDS_125    = 3'h3;
   localparam logic [2:0] FMT_HSTL        = 3'h4;
   localparam logic [2:0] FMT_HSTL_BOOST  = 3'h5;
   localparam logic [2:0] FMT_HIGHZ_A     = 3'h6;
   localparam logic [2:0] FMT_HIGHZ_B     = 3'h7;

   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN   = 2'b11
   } divider_state_t;

endpackage : output_divider_channel_pkg

// *** rtl/phase_divider.sv ***
// one clock divider with half-period phase offset
`timescale 1ns/1ps
module phase_divider (
   input  wire logic                                          i_clk,
   input  wire logic                                          i_rst_b,
   input  wire logic                                          i_power_down,
   input  wire logic                                          i_align,
   input  wire logic [output_divider_channel_pkg::DIVIDE_WIDTH-1:0] i_ratio,
   input  wire logic [output_divider_channel_pkg::PHASE_WIDTH-1:0]  i_phase,
   output logic                                               o_clk
);
   import output_divider_channel_pkg::*;

   divider_state_t            state_reg,  state_next;
   logic [DIVIDE_WIDTH-1:0]   ratio_reg,  ratio_next;
   logic [PHASE_WIDTH-1:0]    phase_reg,  phase_next;
   logic [DIVIDE_WIDTH-1:0]   count_reg,  count_next;
   logic                      loaded_reg, loaded_next;
   logic                      div_reg,    div_next;
   logic                      half_reg;
   logic                      stage_clk;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      ratio_next  = ratio_reg;
      phase_next  = phase_reg;
      count_next  = count_reg;
      loaded_next = 1'b1;
      div_next    = div_reg;
      // new ratio and phase are taken at an alignment and on the first cycle after reset
      if (!loaded_reg || i_align) begin
         ratio_next = i_ratio;
         phase_next = i_phase;
         count_next = {1'b0, i_phase[PHASE_WIDTH-1:2]};
         state_next = (i_phase[PHASE_WIDTH-1:1] == '0) ? ST_RUN : ST_DELAY;
         div_next   = 1'b0;
         if (i_phase[PHASE_WIDTH-1:1] == '0) begin
            count_next = '0;
         end else begin
            count_next = i_phase[DIVIDE_WIDTH:1] - 10'h001;
         end
      end else begin
         case (state_reg)
            ST_OFF: begin
               state_next = ST_RUN;
               count_next = '0;
            end
            ST_DELAY: begin
               // whole input periods of delay, count down to zero
               if (count_reg == '0) begin
                  state_next = ST_RUN;
               end else begin
                  count_next = count_reg - 10'h001;
               end
            end
            ST_RUN: begin
               // high for the first half of ratio+1 periods
               count_next = (count_reg >= ratio_reg) ? '0
                            : count_reg + 10'h001;
               div_next   = (count_next < ratio_reg[DIVIDE_WIDTH-1:1]
                             + {9'h000, ratio_reg[0]});
            end
            default: begin
               state_next = ST_RUN;
               count_next = '0;
            end
         endcase
      end
      if (i_power_down) begin
         state_next = ST_OFF;
         div_next   = 1'b0;
         count_next = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg  <= ST_OFF;
         ratio_reg  <= '0;
         phase_reg  <= '0;
         count_reg  <= '0;
         loaded_reg <= 1'b0;
         div_reg    <= 1'b0;
      end else begin
         state_reg  <= state_next;
         ratio_reg  <= ratio_next;
         phase_reg  <= phase_next;
         count_reg  <= count_next;
         loaded_reg <= loaded_next;
         div_reg    <= div_next;
      end
   end

   // -------------------------------------------------------------
   // half-period step on the falling edge
   // -------------------------------------------------------------
   always_ff @(negedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         half_reg <= 1'b0;
      end else begin
         half_reg <= (ratio_reg == '0) ? (state_reg == ST_RUN) : div_reg;
      end
   end

   // divide by one passes the input clock once running
   always_comb begin
      if (state_reg != ST_RUN && !(phase_reg[0] && half_reg)) begin
         stage_clk = 1'b0;
      end else if (ratio_reg == '0) begin
         // odd phase: the inverted input clock, gated on half a period late
         stage_clk = phase_reg[0] ? (half_reg & ~i_clk) : i_clk;
      end else begin
         stage_clk = phase_reg[0] ? half_reg : div_reg;
      end
      o_clk = stage_clk;
   end

endmodule : phase_divider

// *** rtl/output_divider_channel.sv ***
// register set and output stage of clock channels 0 and 1
//
// Behaviour
// - setting bit 7 of the channel0 control register powers down its divider.
// - bit 6 clear lets channel0 take part in alignment, set excludes it.
// - bits 5:4 pick differential polarity: high, normal, inverted, low.
// - bits 3:1 pick the differential format, lvds levels, hstl or high-z.
// - bit 7 of the single-ended register enables the positive leg driver.
// - bits 6:5 pick positive leg polarity with the same four codes.
// - bit 4 of the single-ended register enables the negative leg driver.
// - bits 3:2 pick negative leg polarity with the same four codes.
// - the 10-bit channel1 divide value spans 0x1b and bits 1:0 of 0x1c.
// - channel1 divides the input clock by the divide value plus one.
// - the 11-bit channel1 phase spans 0x1d and bits 2:0 of 0x1e.
// - channel1 is delayed by the phase value in half input periods.
// - clearing the active-low sync bit aligns all unexcluded dividers.
`timescale 1ns/1ps
module output_divider_channel (
   input  wire logic                                  i_clk,
   input  wire logic                                  i_rst_b,
   input  wire logic [7:0]                            i_reg_addr,
   input  wire logic                                  i_reg_wr,
   input  wire logic [7:0]                            i_reg_wdata,
   output logic      [7:0]                            o_reg_rdata,
   input  wire logic [output_divider_channel_pkg::DIVIDE_WIDTH-1:0]
                                                      i_channel0_divide_value,
   input  wire logic [output_divider_channel_pkg::PHASE_WIDTH-1:0]
                                                      i_channel0_phase_offset,
   output logic                                       o_channel0_diff,
   output logic                                       o_channel0_diff_oe,
   output logic      [2:0]                            o_diff_driver_format,
   output logic                                       o_channel0_pos_leg,
   output logic                                       o_channel0_pos_leg_oe,
   output logic                                       o_channel0_neg_leg,
   output logic                                       o_channel0_neg_leg_oe,
   output logic                                       o_channel1_clk
);
   import output_divider_channel_pkg::*;

   logic [7:0] sync_ctrl_reg,  sync_ctrl_next;
   logic [7:0] ch0_ctrl_reg,   ch0_ctrl_next;
   logic [7:0] ch0_se_reg,     ch0_se_next;
   logic [7:0] div_low_reg,    div_low_next;
   logic [7:0] div_high_reg,   div_high_next;
   logic [7:0] ph_low_reg,     ph_low_next;
   logic [7:0] ph_high_reg,    ph_high_next;
   logic [7:0] rdata_reg,      rdata_next;
   logic       align_reg,      align_next;

   logic                    divider_power_down;
   logic                    align_exclude;
   logic [1:0]              diff_driver_polarity;
   logic                    pos_single_ended_enable;
   logic [1:0]              pos_single_ended_polarity;
   logic                    neg_single_ended_enable;
   logic [1:0]              neg_single_ended_polarity;
   logic [DIVIDE_WIDTH-1:0] channel1_divide_value;
   logic [PHASE_WIDTH-1:0]  channel1_phase_offset;
   logic                    ch0_clk;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic apply_polarity(input logic [1:0] code,
                                           input logic       clk);
      case (code)
         POL_FORCE_HIGH: apply_polarity = 1'b1;
         POL_NONINVERT:  apply_polarity = clk;
         POL_INVERT:     apply_polarity = ~clk;
         POL_FORCE_LOW:  apply_polarity = 1'b0;
         default:        apply_polarity = 1'b0;
      endcase
   endfunction : apply_polarity

   function automatic logic [7:0] write_byte(input logic [7:0] addr,
                                             input logic [7:0] match,
                                             input logic [7:0] mask,
                                             input logic [7:0] data,
                                             input logic [7:0] old);
      write_byte = (addr == match) ? (data & mask) : old;
   endfunction : write_byte

   // -------------------------------------------------------------
   // register file
   // -------------------------------------------------------------
   always_comb begin
      sync_ctrl_next = sync_ctrl_reg;
      ch0_ctrl_next  = ch0_ctrl_reg;
      ch0_se_next    = ch0_se_reg;
      div_low_next   = div_low_reg;
      div_high_next  = div_high_reg;
      ph_low_next    = ph_low_reg;
      ph_high_next   = ph_high_reg;
      if (i_reg_wr) begin
         // reserved bits are dropped on write
         sync_ctrl_next = write_byte(i_reg_addr, ADDR_SYNC_CONTROL,
            MASK_SYNC_CONTROL, i_reg_wdata, sync_ctrl_reg);
         ch0_ctrl_next  = write_byte(i_reg_addr, ADDR_CH0_POWER_SYNC,
            MASK_CH0_POWER_SYNC, i_reg_wdata, ch0_ctrl_reg);
         ch0_se_next    = write_byte(i_reg_addr, ADDR_CH0_SINGLE_ENDED,
            MASK_CH0_SINGLE_ENDED, i_reg_wdata, ch0_se_reg);
         div_low_next   = write_byte(i_reg_addr, ADDR_CH1_DIVIDE_LOW,
            MASK_FULL, i_reg_wdata, div_low_reg);
         div_high_next  = write_byte(i_reg_addr, ADDR_CH1_DIVIDE_HIGH,
            MASK_CH1_DIVIDE_HIGH, i_reg_wdata, div_high_reg);
         ph_low_next    = write_byte(i_reg_addr, ADDR_CH1_PHASE_LOW,
            MASK_FULL, i_reg_wdata, ph_low_reg);
         ph_high_next   = write_byte(i_reg_addr, ADDR_CH1_PHASE_HIGH,
            MASK_CH1_PHASE_HIGH, i_reg_wdata, ph_high_reg);
      end
      // a one-to-zero change of the sync bit starts an alignment
      align_next = sync_ctrl_reg[SYNC_BIT_POS]
                   && !sync_ctrl_next[SYNC_BIT_POS];
      case (i_reg_addr)
         ADDR_SYNC_CONTROL:     rdata_next = sync_ctrl_reg;
         ADDR_CH0_POWER_SYNC:   rdata_next = ch0_ctrl_reg;
         ADDR_CH0_SINGLE_ENDED: rdata_next = ch0_se_reg;
         ADDR_CH1_DIVIDE_LOW:   rdata_next = div_low_reg;
         ADDR_CH1_DIVIDE_HIGH:  rdata_next = div_high_reg;
         ADDR_CH1_PHASE_LOW:    rdata_next = ph_low_reg;
         ADDR_CH1_PHASE_HIGH:   rdata_next = ph_high_reg;
         default:               rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_ctrl_reg <= RST_SYNC_CONTROL;
         ch0_ctrl_reg  <= RST_CH0_POWER_SYNC;
         ch0_se_reg    <= RST_CH0_SINGLE_ENDED;
         div_low_reg   <= RST_CH1_BYTE;
         div_high_reg  <= RST_CH1_BYTE;
         ph_low_reg    <= RST_CH1_BYTE;
         ph_high_reg   <= RST_CH1_BYTE;
         rdata_reg     <= 8'h00;
         align_reg     <= 1'b0;
      end else begin
         sync_ctrl_reg <= sync_ctrl_next;
         ch0_ctrl_reg  <= ch0_ctrl_next;
         ch0_se_reg    <= ch0_se_next;
         div_low_reg   <= div_low_next;
         div_high_reg  <= div_high_next;
         ph_low_reg    <= ph_low_next;
         ph_high_reg   <= ph_high_next;
         rdata_reg     <= rdata_next;
         align_reg     <= align_next;
      end
   end

   assign o_reg_rdata = rdata_reg;

   // -------------------------------------------------------------
   // field decode
   // -------------------------------------------------------------
   assign divider_power_down        = ch0_ctrl_reg[PWR_DOWN_POS];
   assign align_exclude             = ch0_ctrl_reg[ALIGN_EXCL_POS];
   assign diff_driver_polarity      = ch0_ctrl_reg[DIFF_POL_LSB +: 2];
   assign o_diff_driver_format      = ch0_ctrl_reg[DIFF_FMT_LSB +: 3];
   assign pos_single_ended_enable   = ch0_se_reg[POS_EN_POS];
   assign pos_single_ended_polarity = ch0_se_reg[POS_POL_LSB +: 2];
   assign neg_single_ended_enable   = ch0_se_reg[NEG_EN_POS];
   assign neg_single_ended_polarity = ch0_se_reg[NEG_POL_LSB +: 2];
   assign channel1_divide_value = {div_high_reg[1:0], div_low_reg};
   assign channel1_phase_offset = {ph_high_reg[2:0], ph_low_reg};

   // -------------------------------------------------------------
   // dividers
   // -------------------------------------------------------------
   phase_divider u_channel0_divider (
      .i_clk        (i_clk),
      .i_rst_b      (i_rst_b),
      .i_power_down (divider_power_down),
      .i_align      (align_reg && !align_exclude),
      .i_ratio      (i_channel0_divide_value),
      .i_phase      (i_channel0_phase_offset),
      .o_clk        (ch0_clk)
   );

   phase_divider u_channel1_divider (
      .i_clk        (i_clk),
      .i_rst_b      (i_rst_b),
      .i_power_down (1'b0),
      .i_align      (align_reg),
      .i_ratio      (channel1_divide_value),
      .i_phase      (channel1_phase_offset),
      .o_clk        (o_channel1_clk)
   );

   // -------------------------------------------------------------
   // channel0 drivers
   // -------------------------------------------------------------
   always_comb begin
      o_channel0_diff       = apply_polarity(diff_driver_polarity,
                                             ch0_clk);
      o_channel0_diff_oe    = (o_diff_driver_format != FMT_HIGHZ_A)
                              && (o_diff_driver_format != FMT_HIGHZ_B)
                              && !divider_power_down;
      o_channel0_pos_leg    = apply_polarity(pos_single_ended_polarity,
                                             ch0_clk);
      o_channel0_pos_leg_oe = pos_single_ended_enable;
      o_channel0_neg_leg    = apply_polarity(neg_single_ended_polarity,
                                             ch0_clk);
      o_channel0_neg_leg_oe = neg_single_ended_enable;
   end

endmodule : output_divider_channel

// *** tb/output_divider_channel_props.sv ***
// concurrent checks on the output divider channel ports
`timescale 1ns/1ps
module output_divider_channel_props
   import output_divider_channel_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst_b,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_channel0_diff,
   input wire logic       o_channel0_diff_oe,
   input wire logic [2:0] o_diff_driver_format,
   input wire logic       o_channel0_pos_leg,
   input wire logic       o_channel0_pos_leg_oe,
   input wire logic       o_channel0_neg_leg,
   input wire logic       o_channel0_neg_leg_oe
);
   logic [7:0] pwr_reg, pwr_next, se_reg, se_next;

   // -------------------------------------------------------------
   // shadow of the channel0 control registers
   // -------------------------------------------------------------
   always_comb begin
      pwr_next = pwr_reg;
      se_next  = se_reg;
      if (i_reg_wr && i_reg_addr == ADDR_CH0_POWER_SYNC) begin
         pwr_next = i_reg_wdata & 8'hfe;
      end
      if (i_reg_wr && i_reg_addr == ADDR_CH0_SINGLE_ENDED) begin
         se_next = i_reg_wdata & 8'hfc;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pwr_reg <= 8'h14;
         se_reg  <= 8'h00;
      end else begin
         pwr_reg <= pwr_next;
         se_reg  <= se_next;
      end
   end

   function automatic logic pol(input logic [1:0] c, input logic d);
      return (c == 2'b00) ? 1'b1 : (c == 2'b01) ? d :
             (c == 2'b10) ? !d : 1'b0;
   endfunction : pol

   function automatic logic [7:0] rmask(input logic [7:0] a);
      case (a)
         ADDR_SYNC_CONTROL:     return 8'h01;
         ADDR_CH0_POWER_SYNC:   return 8'hfe;
         ADDR_CH0_SINGLE_ENDED: return 8'hfc;
         ADDR_CH1_DIVIDE_HIGH:  return 8'h03;
         ADDR_CH1_PHASE_HIGH:   return 8'h07;
         ADDR_CH1_DIVIDE_LOW, ADDR_CH1_PHASE_LOW: return 8'hff;
         default:               return 8'h00;
      endcase
   endfunction : rmask

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   property p_fmt;
      o_diff_driver_format == pwr_reg[3:1];
   endproperty
   a_fmt: assert property (p_fmt)
      else $error("driver format differs from control field");
   property p_oe;
      o_channel0_diff_oe == !(pwr_reg[7] || pwr_reg[3:2] == 2'b11);
   endproperty
   a_oe: assert property (p_oe)
      else $error("differential enable wrong");
   property p_pos_en;
      o_channel0_pos_leg_oe == se_reg[7];
   endproperty
   a_pos_en: assert property (p_pos_en)
      else $error("positive leg enable wrong");
   property p_neg_en;
      o_channel0_neg_leg_oe == se_reg[4];
   endproperty
   a_neg_en: assert property (p_neg_en)
      else $error("negative leg enable wrong");
   property p_diff_pol;
      (!pwr_reg[7] && pwr_reg[5] == pwr_reg[4]) |->
         o_channel0_diff == !pwr_reg[4];
   endproperty
   a_diff_pol: assert property (p_diff_pol)
      else $error("forced differential level wrong");
   property p_pos_pol;
      (!pwr_reg[7] && pwr_reg[5:4] == 2'b01 && se_reg[7]) |->
         o_channel0_pos_leg == pol(se_reg[6:5], o_channel0_diff);
   endproperty
   a_pos_pol: assert property (p_pos_pol)
      else $error("positive leg polarity wrong");
   property p_neg_pol;
      (!pwr_reg[7] && pwr_reg[5:4] == 2'b01 && se_reg[4]) |->
         o_channel0_neg_leg == pol(se_reg[3:2], o_channel0_diff);
   endproperty
   a_neg_pol: assert property (p_neg_pol)
      else $error("negative leg polarity wrong");
   property p_resv;
      1'b1 |=> (o_reg_rdata & ~rmask($past(i_reg_addr))) == 8'h00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved or unmapped read bits not zero");

   c_sync: cover property (i_reg_wr && i_reg_addr == 8'h14 && !i_reg_wdata[0]);
   c_pd: cover property (pwr_reg[7]);
   c_unm: cover property (i_reg_addr > ADDR_CH1_PHASE_HIGH);
endmodule : output_divider_channel_props

bind output_divider_channel output_divider_channel_props u_props (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_channel0_diff(o_channel0_diff),
   .o_channel0_diff_oe(o_channel0_diff_oe),
   .o_diff_driver_format(o_diff_driver_format),
   .o_channel0_pos_leg(o_channel0_pos_leg),
   .o_channel0_pos_leg_oe(o_channel0_pos_leg_oe),
   .o_channel0_neg_leg(o_channel0_neg_leg),
   .o_channel0_neg_leg_oe(o_channel0_neg_leg_oe));

// *** tb/tb.sv ***
// self-checking bench for the output divider channel
`timescale 1ns/1ps
module tb;
   import output_divider_channel_pkg::*;
   logic                    i_clk, i_rst_b, i_reg_wr;
   logic [7:0]              i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [DIVIDE_WIDTH-1:0] div0;
   logic [PHASE_WIDTH-1:0]  ph0;
   logic [2:0]              fmt;
   logic                    dif, dif_oe, pos, pos_oe, neg, neg_oe, ch1;
   logic [7:0]              bq[$];
   realtime                 mq[$];
   int                      error_cnt = 0, total_checks = 0;
   event                    rd_ev, leg_ev, clk_ev;
   logic [7:0] adr [7] = '{8'h14, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e};
   logic [7:0] rst [7] = '{8'h01, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] msk [7] = '{8'h01, 8'hfe, 8'hfc, 8'hff, 8'h03, 8'hff, 8'h07};
   int         nv [5] = '{0, 1, 1023, 0, 0};

   output_divider_channel dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .i_channel0_divide_value(div0),
      .i_channel0_phase_offset(ph0), .o_channel0_diff(dif),
      .o_channel0_diff_oe(dif_oe), .o_diff_driver_format(fmt),
      .o_channel0_pos_leg(pos), .o_channel0_pos_leg_oe(pos_oe),
      .o_channel0_neg_leg(neg), .o_channel0_neg_leg_oe(neg_oe),
      .o_channel1_clk(ch1));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk_b

   task automatic chk_t(input realtime got, input realtime exp);
      total_checks++;
      if (got != exp) begin
         error_cnt++;
         $display("MISMATCH %0t span %0.1f expected %0.1f", $time, got, exp);
      end
   endtask : chk_t

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      i_reg_addr  = a;
      i_reg_wdata = d;
      i_reg_wr    = 1'b1;
      @(posedge i_clk) #1;
      i_reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk) #1;
      i_reg_addr = a;
      bq.push_back(e);
      @(posedge i_clk) #1;
      -> rd_ev;
   endtask : rd

   task automatic meas(input int n, input int p);
      repeat (2 * n + p + 8) @(posedge i_clk);
      mq.push_back((n + 1) * 25.0);
      mq.push_back(p * 12.5);
      -> clk_ev;
      wait (mq.size() == 0);
   endtask : meas

   // -------------------------------------------------------------
   // result watchers
   // -------------------------------------------------------------
   always @(rd_ev) chk_b(o_reg_rdata, bq.pop_front());
   always @(leg_ev) chk_b({5'h00, dif, pos, neg}, bq.pop_front());
   always begin : clk_watch
      realtime t0, t1;
      @(clk_ev);
      @(posedge dif) t0 = $realtime;
      @(posedge ch1) t1 = $realtime;
      @(posedge ch1);
      chk_t($realtime - t1, mq.pop_front());
      chk_t(t1 - t0, mq.pop_front());
   end

   initial begin
      #2ms;
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      test_done();
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      logic [7:0] d;
      int         n, p, pn, pp;
      i_rst_b = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      div0 = '0;
      ph0 = '0;
      void'($urandom(32'he542));
      nv[3] = $urandom_range(2, 60);
      nv[4] = $urandom_range(61, 300);
      repeat (4) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      foreach (adr[i]) rd(adr[i], rst[i]);
      foreach (adr[i]) begin
         d = 8'($urandom);
         wr(adr[i], d);
         rd(adr[i], d & msk[i]);
      end
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      for (int f = 0; f < 8; f++) wr(ADDR_CH0_POWER_SYNC, 8'(f * 2));
      wr(ADDR_CH0_POWER_SYNC, 8'hd4);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CH0_POWER_SYNC, (c == 0) ? 8'h04 : (c == 3) ? 8'h34 : 8'h14);
         wr(ADDR_CH0_SINGLE_ENDED, {1'b1, c[1:0], 1'b1, c[1:0], 2'b00});
         repeat (3) @(posedge i_clk);
         if (c == 0 || c == 3) begin
            bq.push_back((c == 0) ? 8'h07 : 8'h00);
            -> leg_ev;
         end
      end
      wr(ADDR_CH0_POWER_SYNC, 8'h14);
      wr(ADDR_SYNC_CONTROL, 8'h01);
      foreach (nv[i]) begin
         n = nv[i];
         p = $urandom_range(1, 2 * n + 1);
         wr(ADDR_CH1_DIVIDE_LOW, n[7:0]);
         wr(ADDR_CH1_DIVIDE_HIGH, {6'h00, n[9:8]});
         wr(ADDR_CH1_PHASE_LOW, p[7:0]);
         wr(ADDR_CH1_PHASE_HIGH, {5'h00, p[10:8]});
         if (i > 0) meas(pn, pp);
         div0 = n[9:0];
         wr(ADDR_SYNC_CONTROL, 8'h00);
         wr(ADDR_SYNC_CONTROL, 8'h01);
         meas(n, p);
         pn = n;
         pp = p;
      end
      test_done();
   end
endmodule : tb
